// [design/wolrx_pkg.sv]
// Package: register map, field positions and timing for the wake-on-LAN receive block
package wolrx_pkg;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 16;
    localparam logic [8:0] OFF_CFG = 9'h134;
    localparam logic [8:0] OFF_STATUS = 9'h135;
    localparam logic [8:0] OFF_PASS0 = 9'h139;
    localparam logic [8:0] OFF_PASS1 = 9'h13A;
    localparam logic [8:0] OFF_PASS2 = 9'h13B;
    localparam logic [8:0] OFF_IRQ_STAT = 9'h1F0;
    localparam logic [8:0] OFF_IRQ_EN = 9'h1F1;
    localparam logic [8:0] OFF_IRQ_CLR = 9'h1F2;
    // Configuration fields
    localparam int unsigned CFG_CLEAR = 11;
    localparam int unsigned CFG_LEN_LO = 9;
    localparam int unsigned CFG_LEVEL = 8;
    localparam int unsigned CFG_FEAT = 7;
    localparam int unsigned CFG_PASS = 5;
    localparam int unsigned CFG_UCAST = 4;
    localparam int unsigned CFG_BCAST = 2;
    localparam int unsigned CFG_PATTERN = 1;
    localparam int unsigned CFG_MAGIC = 0;
    localparam logic [15:0] CFG_RESET = 16'h0004;
    localparam logic [15:0] CFG_WMASK = 16'h07B7;
    // Status fields
    localparam int unsigned ST_MAGIC = 0;
    localparam int unsigned ST_PATTERN = 1;
    localparam int unsigned ST_BCAST = 2;
    localparam int unsigned ST_UCAST = 4;
    localparam int unsigned ST_ATTACK = 5;
    localparam int unsigned ST_BADCRC = 6;
    localparam int unsigned ST_SFDERR = 7;
    localparam logic [15:0] ST_MASK = 16'h00F7;
    // Interrupt event bits
    localparam int unsigned NUM_EV = 3;
    localparam int unsigned EV_WAKE = 0;
    localparam int unsigned EV_ATTACK = 1;
    localparam int unsigned EV_ERROR = 2;
    // Pulse lengths in 125 MHz cycles, index by the two-bit length field
    localparam logic [6:0] PULSE_LEN_0 = 7'd8;
    localparam int unsigned PULSE_SHIFT_MAX = 3;
    localparam int unsigned CNT_W = 7;

    typedef struct packed {
        logic magic;
        logic pattern;
        logic bcast;
        logic ucast;
        logic pass_ok;
        logic bad_crc;
        logic sfd_err;
    } wolrx_frame_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } wolrx_bus_s;
endpackage : wolrx_pkg

// [design/wolrx_stretch.sv]
// Wake output shaper: pulse of programmed length or held level
`timescale 1ns/1ns
`default_nettype none
module wolrx_stretch
    import wolrx_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic level_mode_i,
    input wire logic [1:0] len_sel_i,
    input wire logic clear_i,
    output logic wake_o
);
    typedef enum logic [1:0] {WS_IDLE = 2'b00, WS_PULSE = 2'b01, WS_LEVEL = 2'b11} wolrx_ws_e;

    wolrx_ws_e state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] len_cycles;

    assign len_cycles = CNT_W'(PULSE_LEN_0 << len_sel_i);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            WS_IDLE:
            begin
                if (fire_i)
                begin
                    nxt_state = level_mode_i ? WS_LEVEL : WS_PULSE;
                    nxt_cnt = len_cycles - CNT_W'(1);
                end
            end
            WS_PULSE:
            begin
                if (cnt_ff == '0)
                    nxt_state = WS_IDLE;
                else
                    nxt_cnt = cnt_ff - CNT_W'(1);
            end
            WS_LEVEL:
            begin
                // clear drops held level; new event wins
                if (clear_i && !fire_i)
                    nxt_state = WS_IDLE;
            end
            default:
                nxt_state = WS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= WS_IDLE;
            cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign wake_o = (state_ff != WS_IDLE);

    // Counts cycles of the current pulse for the width check
    logic [CNT_W:0] width_ff;
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            width_ff <= '0;
        else if (state_ff == WS_PULSE)
            width_ff <= width_ff + (CNT_W+1)'(1);
        else
            width_ff <= '0;
    end

    chk_pulse_width: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_ff == WS_PULSE && nxt_state == WS_IDLE) |-> (width_ff + (CNT_W+1)'(1)) <= (CNT_W+1)'(64))
        else $error("wake pulse longer than longest stretch");
    chk_pulse_min8: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_ff == WS_IDLE && fire_i && !level_mode_i) |=> wake_o [*8])
        else $error("wake pulse shorter than eight cycles");
    chk_pulse_len8: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_ff == WS_IDLE && fire_i && !level_mode_i && len_sel_i == 2'b00) |=> ##8 !wake_o)
        else $error("eight cycle pulse wrong length");
    chk_level_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_ff == WS_LEVEL && !clear_i) |=> wake_o)
        else $error("level wake dropped without clear");
    chk_level_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_ff == WS_LEVEL && clear_i && !fire_i) |=> !wake_o)
        else $error("level wake not cleared");
    cov_pulse: cover property (@(posedge ref_clk_i) disable iff (rst_i) state_ff == WS_PULSE ##1 state_ff == WS_IDLE);
    cov_level: cover property (@(posedge ref_clk_i) disable iff (rst_i) state_ff == WS_LEVEL ##1 state_ff == WS_IDLE);
endmodule : wolrx_stretch
`default_nettype wire

// [design/wolrx_top.sv]
// Wake-on-LAN receive configuration, status, password and wake output
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Writing clear bit in level mode drops held wake; bit self-clears; pulse mode ignores.
// - Pulse length select 00/01/10/11 gives 8/16/32/64 cycles.
// - Mode bit set means level hold until cleared; reset value selects pulse.
// - Feature enable gates wake detection, CRC check and timestamp indication; resets clear.
// - Password enable requires matching password with magic packet; resets disabled.
// - Unicast enable makes valid unicast frames wake; resets clear.
// - Broadcast enable makes broadcast frames wake; resets set.
// - Pattern enable makes pattern matches wake; resets clear.
// - Magic enable makes valid magic packets wake; resets clear.
// - Status flags latch on events and clear when read.
// - Password is 48 bits in three 16-bit words, low first, reset zero.
module wolrx_top
    import wolrx_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire wolrx_pkg::wolrx_bus_s bus_i,
    output logic [wolrx_pkg::DATA_W-1:0] rdata_o,
    input wire logic frame_valid_i,
    input wire wolrx_pkg::wolrx_frame_s frame_i,
    input wire logic [47:0] frame_pass_i,
    input wire logic sof_i,
    output logic crc_check_en_o,
    output logic sof_ind_o,
    output logic wake_o,
    output logic irq_o
);
    import wolrx_pkg::*;

    logic [15:0] cfg_ff, nxt_cfg;
    logic [15:0] status_ff, nxt_status;
    logic [2:0][15:0] pass_ff, nxt_pass;
    logic [NUM_EV-1:0] irq_stat_ff, nxt_irq_stat;
    logic [NUM_EV-1:0] irq_en_ff, nxt_irq_en;
    logic [15:0] rdata_ff, nxt_rdata;
    logic sof_ff, nxt_sof;

    logic wr_cfg, rd_status, wr_iclr, wr_ien;
    logic feat_on, pass_ok, magic_ok, attack, wake_fire;
    logic [15:0] ev_status;
    logic [NUM_EV-1:0] ev_irq;

    assign wr_cfg = bus_i.wr && bus_i.addr == OFF_CFG;
    assign rd_status = bus_i.rd && bus_i.addr == OFF_STATUS;
    assign wr_iclr = bus_i.wr && bus_i.addr == OFF_IRQ_CLR;
    assign wr_ien = bus_i.wr && bus_i.addr == OFF_IRQ_EN;

    assign feat_on = cfg_ff[CFG_FEAT];
    assign pass_ok = !cfg_ff[CFG_PASS] || (frame_pass_i == {pass_ff[2], pass_ff[1], pass_ff[0]});
    assign magic_ok = frame_i.magic && pass_ok;
    assign attack = frame_i.magic && cfg_ff[CFG_PASS] && !pass_ok;

    always_comb
    begin
        ev_status = '0;
        if (frame_valid_i && feat_on)
        begin
            ev_status[ST_MAGIC] = magic_ok;
            ev_status[ST_PATTERN] = frame_i.pattern;
            ev_status[ST_BCAST] = frame_i.bcast;
            ev_status[ST_UCAST] = frame_i.ucast;
            ev_status[ST_ATTACK] = attack;
            ev_status[ST_BADCRC] = frame_i.bad_crc;
            ev_status[ST_SFDERR] = frame_i.sfd_err;
        end
    end

    assign wake_fire = (ev_status[ST_UCAST] && cfg_ff[CFG_UCAST])
                     || (ev_status[ST_BCAST] && cfg_ff[CFG_BCAST])
                     || (ev_status[ST_PATTERN] && cfg_ff[CFG_PATTERN])
                     || (ev_status[ST_MAGIC] && cfg_ff[CFG_MAGIC]);

    assign ev_irq[EV_WAKE] = wake_fire;
    assign ev_irq[EV_ATTACK] = ev_status[ST_ATTACK];
    assign ev_irq[EV_ERROR] = ev_status[ST_BADCRC] || ev_status[ST_SFDERR];

    // Configuration and password registers
    always_comb
    begin
        nxt_cfg = cfg_ff;
        nxt_pass = pass_ff;
        nxt_cfg[CFG_CLEAR] = 1'b0;
        if (wr_cfg)
        begin
            nxt_cfg = bus_i.wdata & CFG_WMASK;
            nxt_cfg[CFG_CLEAR] = bus_i.wdata[CFG_CLEAR];
        end
        if (bus_i.wr && bus_i.addr == OFF_PASS0)
            nxt_pass[0] = bus_i.wdata;
        if (bus_i.wr && bus_i.addr == OFF_PASS1)
            nxt_pass[1] = bus_i.wdata;
        if (bus_i.wr && bus_i.addr == OFF_PASS2)
            nxt_pass[2] = bus_i.wdata;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_ff <= CFG_RESET;
            pass_ff <= '0;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            pass_ff <= nxt_pass;
        end
    end

    // Status and interrupt registers; a new event always beats a clear
    always_comb
    begin
        nxt_status = status_ff;
        nxt_irq_stat = irq_stat_ff;
        nxt_irq_en = irq_en_ff;
        if (rd_status)
            nxt_status = '0;
        nxt_status = (nxt_status | ev_status) & ST_MASK;
        if (wr_iclr)
            nxt_irq_stat = irq_stat_ff & ~bus_i.wdata[NUM_EV-1:0];
        nxt_irq_stat = nxt_irq_stat | ev_irq;
        if (wr_ien)
            nxt_irq_en = bus_i.wdata[NUM_EV-1:0];
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            status_ff <= '0;
            irq_stat_ff <= '0;
            irq_en_ff <= '0;
        end
        else
        begin
            status_ff <= nxt_status;
            irq_stat_ff <= nxt_irq_stat;
            irq_en_ff <= nxt_irq_en;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_comb
    begin
        nxt_rdata = '0;
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                OFF_CFG: nxt_rdata = cfg_ff;
                OFF_STATUS: nxt_rdata = status_ff;
                OFF_PASS0: nxt_rdata = pass_ff[0];
                OFF_PASS1: nxt_rdata = pass_ff[1];
                OFF_PASS2: nxt_rdata = pass_ff[2];
                OFF_IRQ_STAT: nxt_rdata = 16'(irq_stat_ff);
                OFF_IRQ_EN: nxt_rdata = 16'(irq_en_ff);
                default: nxt_rdata = '0;
            endcase
        end
    end

    // timestamp start-of-frame indication only with features on
    assign nxt_sof = sof_i && feat_on;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= '0;
            sof_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            sof_ff <= nxt_sof;
        end
    end

    assign rdata_o = rdata_ff;
    assign sof_ind_o = sof_ff;
    assign crc_check_en_o = feat_on;
    assign irq_o = |(irq_stat_ff & irq_en_ff);

    wolrx_stretch u_stretch (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .fire_i(wake_fire),
        .level_mode_i(cfg_ff[CFG_LEVEL]),
        .len_sel_i(cfg_ff[CFG_LEN_LO +: 2]),
        .clear_i(cfg_ff[CFG_CLEAR]),
        .wake_o(wake_o)
    );

    chk_clear_self: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cfg_ff[CFG_CLEAR] && !wr_cfg |=> !cfg_ff[CFG_CLEAR])
        else $error("wake clear bit did not self-clear");
    chk_feature_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !feat_on && !rd_status |=> status_ff == $past(status_ff))
        else $error("status changed with features off");
    chk_attack_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        frame_valid_i && feat_on && attack |=> status_ff[ST_ATTACK] && !status_ff[ST_MAGIC] || $past(status_ff[ST_MAGIC]))
        else $error("password attack not flagged");
    chk_ucast_wake: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        frame_valid_i && feat_on && frame_i.ucast && cfg_ff[CFG_UCAST] |=> irq_stat_ff[EV_WAKE])
        else $error("unicast wake lost");
    chk_bcast_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        frame_valid_i && feat_on && frame_i.bcast && cfg_ff[CFG_BCAST] |=> irq_stat_ff[EV_WAKE])
        else $error("broadcast wake lost");
    chk_magic_wake: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        frame_valid_i && feat_on && magic_ok && cfg_ff[CFG_MAGIC] |=> wake_o)
        else $error("magic packet did not wake");
    chk_pattern_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ev_status == 16'(1 << ST_PATTERN) && !cfg_ff[CFG_PATTERN] |-> !wake_fire)
        else $error("disabled pattern raised wake");
    chk_status_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_status && ev_status == '0 |=> status_ff == '0 && rdata_o == $past(status_ff))
        else $error("status not cleared by read");
    chk_status_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ev_status[ST_BADCRC] |=> status_ff[ST_BADCRC])
        else $error("bad crc flag lost");
    chk_pass_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        bus_i.wr && bus_i.addr == OFF_PASS1 |=> pass_ff[1] == $past(bus_i.wdata))
        else $error("password word not stored");
    chk_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        irq_o == |(irq_stat_ff & irq_en_ff))
        else $error("interrupt output mismatch");
    cov_magic: cover property (@(posedge ref_clk_i) disable iff (rst_i) magic_ok && feat_on && frame_valid_i);
    cov_attack: cover property (@(posedge ref_clk_i) disable iff (rst_i) attack && feat_on && frame_valid_i);
    cov_read_clear: cover property (@(posedge ref_clk_i) disable iff (rst_i) rd_status && status_ff != '0);
endmodule : wolrx_top
`default_nettype wire

// [tb/wolrx_host_model.sv]
// Host-side wake logic model: measures the width of each wake pulse
`timescale 1ns/1ns
`default_nettype none
module wolrx_host_model
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wake_i,
    output var int unsigned pulse_len_o
);
    int unsigned run_len_ff;
    // Sampled at the rising edge, as real system logic in this domain would
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            run_len_ff <= 0;
            pulse_len_o <= 0;
        end
        else if (wake_i === 1'b1)
            run_len_ff <= run_len_ff + 1;
        else if (run_len_ff != 0)
        begin
            pulse_len_o <= run_len_ff;
            run_len_ff <= 0;
        end
    end
endmodule : wolrx_host_model
`default_nettype wire

// [tb/tb_wake_on_lan_receive_config.sv]
// Self-checking bench for the wake-on-LAN receive block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_wake_on_lan_receive_config;
    import wolrx_pkg::*;
    localparam logic [6:0] F_MAGIC = 7'h40;
    localparam logic [6:0] F_PAT = 7'h20;
    localparam logic [6:0] F_BC = 7'h10;
    localparam logic [6:0] F_UC = 7'h08;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    wolrx_bus_s bus = '0;
    logic frame_valid = 1'b0;
    wolrx_frame_s frame = '0;
    logic [47:0] frame_pass = '0;
    logic sof = 1'b0;
    logic [15:0] rdata;
    logic crc_en;
    logic sof_ind;
    logic wake;
    logic irq;
    int unsigned pulse_len;
    int n_fail = 0;
    int comparisons = 0;
    logic [15:0] v;

    wolrx_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .frame_valid_i(frame_valid),
        .frame_i(frame), .frame_pass_i(frame_pass), .sof_i(sof), .crc_check_en_o(crc_en), .sof_ind_o(sof_ind),
        .wake_o(wake), .irq_o(irq));
    wolrx_host_model host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wake_i(wake), .pulse_len_o(pulse_len));

    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic reg_wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus.wr <= 1'b0;
        // Let the launching edge settle before callers look at outputs
        #1;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task automatic send(input logic [6:0] f, input logic [47:0] p);
        @(posedge ref_clk_i);
        frame <= wolrx_frame_s'(f);
        frame_pass <= p;
        frame_valid <= 1'b1;
        @(posedge ref_clk_i);
        frame_valid <= 1'b0;
        #1;
    endtask : send

    task automatic wait_idle();
        for (int i = 0; i < 200 && wake !== 1'b0; i++)
        begin
            @(posedge ref_clk_i);
            #1;
        end
        @(posedge ref_clk_i);
        #1;
    endtask : wait_idle

    task automatic t_regs();
        reg_rd(OFF_CFG, v);
        `CHK(v, 16'h0004) // reset value
        for (int i = 0; i < 3; i++)
        begin
            reg_rd(OFF_PASS0 + 9'(i), v);
            `CHK(v, 16'h0000) // password reset
        end
        reg_wr(OFF_CFG, 16'hFFFF);
        reg_rd(OFF_CFG, v);
        `CHK(v, 16'h07B7) // clear bit reads back zero
        reg_wr(9'h100, 16'hFFFF);
        reg_rd(9'h100, v);
        `CHK(v, 16'h0000)
        reg_wr(OFF_CFG, 16'h0004);
    endtask : t_regs

    task automatic t_feature();
        send(F_BC, '0);
        `CHK(wake, 1'b0) // features off
        `CHK(crc_en, 1'b0) // crc check off
        @(posedge ref_clk_i);
        sof <= 1'b1;
        @(posedge ref_clk_i);
        sof <= 1'b0;
        #1 `CHK(sof_ind, 1'b0) // no indication when off
        reg_wr(OFF_CFG, 16'h0084);
        `CHK(crc_en, 1'b1) // crc check on
        @(posedge ref_clk_i);
        sof <= 1'b1;
        @(posedge ref_clk_i);
        sof <= 1'b0;
        #1 `CHK(sof_ind, 1'b1) // timestamp indication
    endtask : t_feature

    task automatic t_pulse();
        for (int len = 0; len < 4; len++)
        begin
            reg_wr(OFF_CFG, 16'h0084 | (16'(len) << 9));
            send(F_BC, '0);
            `CHK(wake, 1'b1) // broadcast wakes
            // Clear in pulse mode must leave the pulse alone
            if (len == 3)
                reg_wr(OFF_CFG, 16'h0E84);
            wait_idle();
            `CHK(pulse_len, 32'(8 << len)) // pulse width
            reg_rd(OFF_STATUS, v);
            `CHK(v, 16'h0004) // broadcast flag
            reg_rd(OFF_STATUS, v);
            `CHK(v, 16'h0000) // cleared on read
        end
    endtask : t_pulse

    task automatic t_enables();
        logic [6:0] fr[3] = '{F_UC, F_PAT, F_MAGIC};
        logic [15:0] en[3] = '{16'h0010, 16'h0002, 16'h0001};
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(OFF_CFG, 16'h0080);
            send(fr[i], '0);
            `CHK(wake, 1'b0) // disabled
            reg_wr(OFF_CFG, 16'h0080 | en[i]);
            send(fr[i], '0);
            `CHK(wake, 1'b1) // enabled
            wait_idle();
        end
        reg_rd(OFF_STATUS, v);
        `CHK(v, 16'h0013) // flags latch
    endtask : t_enables

    task automatic t_level_irq();
        reg_wr(OFF_CFG, 16'h0184);
        reg_wr(OFF_IRQ_EN, 16'h0001);
        send(F_BC, '0);
        repeat (100) @(posedge ref_clk_i);
        #1 `CHK(wake, 1'b1) // level held
        `CHK(irq, 1'b1)
        reg_wr(OFF_CFG, 16'h0984);
        repeat (2) @(posedge ref_clk_i);
        #1 `CHK(wake, 1'b0) // level cleared
        reg_rd(OFF_CFG, v);
        `CHK(v, 16'h0184) // self-clearing
        reg_rd(OFF_IRQ_STAT, v);
        `CHK(v, 16'h0001)
        reg_wr(OFF_IRQ_EN, 16'h0000);
        `CHK(irq, 1'b0)
        reg_wr(OFF_IRQ_EN, 16'h0001);
        `CHK(irq, 1'b1)
        reg_wr(OFF_IRQ_CLR, 16'h0001);
        #1 `CHK(irq, 1'b0)
        reg_rd(OFF_STATUS, v);
    endtask : t_level_irq

    task automatic t_password();
        reg_wr(OFF_PASS0, 16'h1111);
        reg_wr(OFF_PASS1, 16'h2222);
        reg_wr(OFF_PASS2, 16'h3333);
        reg_wr(OFF_CFG, 16'h00A1);
        send(F_MAGIC, 48'h3333_2222_1111);
        `CHK(wake, 1'b1) // matching password
        wait_idle();
        send(F_MAGIC, 48'h1111_2222_3333);
        `CHK(wake, 1'b0) // wrong password refused
        reg_rd(OFF_STATUS, v);
        `CHK(v, 16'h0021) // magic then attack
        reg_wr(OFF_CFG, 16'h0081);
        send(F_MAGIC, 48'h1111_2222_3333);
        `CHK(wake, 1'b1) // no check when disabled
        wait_idle();
    endtask : t_password

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_feature();
        t_pulse();
        t_enables();
        t_level_irq();
        t_password();
        stop_test();
    end

    // The whole sequence needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        stop_test();
    end
endmodule : tb_wake_on_lan_receive_config
`default_nettype wire
